// ==== rtl/mupf_defines.svh ====
// Constants of the measurement push framer: command offsets, codes, sizes, timing.
// Assumes inclusion by bare name from every framer file.
`ifndef MUPF_DEFINES_SVH
`define MUPF_DEFINES_SVH

// Command offsets on the control port
`define MUPF_REG_CHAN_SEL    16'h01e0
`define MUPF_REG_ERASE       16'h004c
`define MUPF_REG_DIRECTION   16'h0ca4
`define MUPF_REG_PORT_LONG   16'h10e0
`define MUPF_REG_PORT_SHORT  16'h10e2
`define MUPF_REG_TARGET_IP   16'h10e4
`define MUPF_REG_TIMED_A     16'h01f8

// Codes and field values
`define MUPF_ERASE_CODE      16'h024e
`define MUPF_DATA_PORT       16'h1392
`define MUPF_PUSH_ID         4'hd
`define MUPF_LEN_BASE        12'h00c
`define MUPF_SEL_MAX         8'h0f
`define MUPF_HDR_LAST        4'hd
`define MUPF_NO_CHAN         3'h4
`define MUPF_BYTE_LAST       2'h3

// Sizes
`define MUPF_NCHAN           4
`define MUPF_DEPTH           16
`define MUPF_SLOT_W          4
`define MUPF_HDR_W           112

// Timing, in nanoseconds
`define MUPF_CLK_PERIOD_NS   32'h0000_0014
`define MUPF_FRAME_PERIOD_NS 32'h000f_4240
`define MUPF_NS_WRAP         32'h3b9a_ca00

`endif

// ==== rtl/mupf_pkg.sv ====
// Types shared by the framer, its sample store and its time base.
// Assumes mupf_defines.svh is on the include path.
`include "mupf_defines.svh"

package mupf_pkg;

    // Frame sender phase
    typedef enum logic [0:0] {MUPF_IDLE, MUPF_SEND} mupf_phase_t;

    // Whole state of the framer
    typedef struct packed {
        logic [3:0]                sel;       // Channel selection as written
        logic [15:0]               port;      // Target port
        logic [31:0]               ip;        // Target address
        logic                      dir_neg;   // Negative direction
        logic                      ip_set;    // Target address given
        logic                      port_set;  // Target port given
        logic [15:0]               erase_val; // Last erase word
        logic [31:0]               last_a;    // Newest channel A value
        logic                      wr_bank;   // Collecting bank
        logic [`MUPF_SLOT_W:0]     n;         // Sample times collected
        logic [31:0]               first_ts;  // Stamp of first sample
        logic [31:0]               first_cnt; // Counter of first sample
        logic [31:0]               meas_cnt;  // Running sample counter
        mupf_phase_t               phase;
        logic [3:0]                f_sel;     // Selection frozen for frame
        logic [`MUPF_SLOT_W:0]     f_n;       // Sample times in frame
        logic [`MUPF_HDR_W-1:0]    hdr;       // Frame header bytes
        logic                      in_pl;     // In payload part
        logic [3:0]                hidx;      // Header byte index
        logic [`MUPF_SLOT_W-1:0]   t;         // Payload sample time
        logic [2:0]                c;         // Payload channel
        logic [1:0]                b;         // Byte within value
        logic                      tx_valid;
        logic [7:0]                tx_data;
        logic                      tx_last;
        logic [15:0]               tx_port;
        logic [31:0]               tx_ip;
        logic [15:0]               tx_src;
        logic                      rsp_valid;
        logic [31:0]               rsp_data;
        logic                      rsp_err;
        logic                      erase;
        logic                      active;
    } mupf_frm_t;

    // Sample storage, two banks
    typedef struct packed {
        logic [1:0][`MUPF_DEPTH-1:0][`MUPF_NCHAN-1:0][31:0] word;
    } mupf_store_t;

    // Time base state
    typedef struct packed {
        logic [15:0] cyc;  // Cycles into the millisecond
        logic [31:0] ns;   // Nanoseconds into the second
        logic        tick; // Millisecond boundary
    } mupf_tb_t;

endpackage

// ==== rtl/mupf_store_if.sv ====
// Write and read path between the framer and its sample store.
// Assumes both ends run on the same clock; reads are combinational.
`timescale 1ns/1ns
`include "mupf_defines.svh"

interface mupf_store_if;
    logic                                wr_en;   // Store one sample time
    logic                                wr_bank;
    logic [`MUPF_SLOT_W-1:0]             wr_slot;
    logic [`MUPF_NCHAN-1:0][31:0]        wr_data; // All channels at once
    logic                                rd_bank;
    logic [`MUPF_SLOT_W-1:0]             rd_slot;
    logic [1:0]                          rd_chan;
    logic [31:0]                         rd_data;

    modport framer (output wr_en, wr_bank, wr_slot, wr_data, rd_bank, rd_slot, rd_chan, input rd_data);
    modport store  (input wr_en, wr_bank, wr_slot, wr_data, rd_bank, rd_slot, rd_chan, output rd_data);
endinterface

// ==== rtl/mupf_store.sv ====
// Two-bank flip-flop store for one millisecond of samples per bank.
// Assumes the framer never reads the bank it is writing.
`timescale 1ns/1ns
`include "mupf_defines.svh"

module mupf_store (
    input  logic            clk,
    input  logic            rst_n,
    input  logic            ce,
    mupf_store_if.store     sif
);
    mupf_pkg::mupf_store_t q;  // Stored words
    mupf_pkg::mupf_store_t d;  // Next stored words

    // Write one sample time into the addressed slot
    always_comb
    begin
        d = q;
        if (sif.wr_en)
        begin
            d.word[sif.wr_bank][sif.wr_slot] = sif.wr_data;
        end
    end

    // Clear on reset so reads never show stale data
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    // Unregistered read, used one cycle ahead of the byte
    assign sif.rd_data = q.word[sif.rd_bank][sif.rd_slot][sif.rd_chan];
endmodule

// ==== rtl/mupf_timebase.sv ====
// Millisecond tick and nanosecond stamp that wraps each second.
// Assumes the clock period divides the nanosecond step exactly.
`timescale 1ns/1ns
`include "mupf_defines.svh"

module mupf_timebase #(
    parameter int unsigned MS_CYCLES = `MUPF_FRAME_PERIOD_NS / `MUPF_CLK_PERIOD_NS
) (
    input  logic        clk,
    input  logic        rst_n,
    input  logic        ce,
    output logic [31:0] ts_ns,
    output logic        ms_tick
);
    mupf_pkg::mupf_tb_t q;  // Counters
    mupf_pkg::mupf_tb_t d;  // Next counters

    // Count cycles and nanoseconds
    always_comb
    begin
        d = q;
        d.tick = 1'b0;
        if (q.cyc == 16'(MS_CYCLES - 1))
        begin
            d.cyc  = '0;
            d.tick = 1'b1;
        end
        else
        begin
            d.cyc = q.cyc + 16'h0001;
        end
        if (q.ns >= `MUPF_NS_WRAP - `MUPF_CLK_PERIOD_NS)
        begin
            d.ns = '0;
        end
        else
        begin
            d.ns = q.ns + `MUPF_CLK_PERIOD_NS;
        end
    end

    // Register the counters
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    assign ts_ns   = q.ns;
    assign ms_tick = q.tick;
endmodule

// ==== rtl/mupf_framer.sv ====
// Measurement push framer: control-port commands, sample collection, frame bytes.
// Assumes samples and commands arrive on clk; the UDP stack takes bytes by tx_ready.
`timescale 1ns/1ns
`include "mupf_defines.svh"

module mupf_framer #(
    parameter int unsigned MS_CYCLES = `MUPF_FRAME_PERIOD_NS / `MUPF_CLK_PERIOD_NS
) (
    input  logic                          clk,
    input  logic                          rst_n,
    input  logic                          ce,
    input  logic                          cmd_valid,
    input  logic                          cmd_write,
    input  logic [15:0]                   cmd_addr,
    input  logic [31:0]                   cmd_wdata,
    output logic                          rsp_valid,
    output logic [31:0]                   rsp_rdata,
    output logic                          rsp_err,
    input  logic                          sample_valid,
    input  logic [`MUPF_NCHAN-1:0][31:0]  sample_data,
    input  logic [31:0]                   sensor_status,
    output logic                          tx_valid,
    input  logic                          tx_ready,
    output logic [7:0]                    tx_data,
    output logic                          tx_last,
    output logic [31:0]                   tx_dst_ip,
    output logic [15:0]                   tx_dst_port,
    output logic [15:0]                   tx_src_port,
    output logic                          push_active,
    output logic                          erase_all
);
    mupf_pkg::mupf_frm_t          q;         // Framer state
    mupf_pkg::mupf_frm_t          d;         // Next framer state
    logic [31:0]                  ts_ns;     // Current stamp
    logic                         ms_tick;   // Millisecond boundary
    logic [`MUPF_NCHAN-1:0][31:0] samp_adj;  // Samples after direction
    mupf_store_if                 sif ();

    // Lowest selected channel at or above a start index
    function automatic logic [2:0] next_chan(input logic [3:0] sel, input logic [2:0] from);
        logic [2:0] r;
        r = `MUPF_NO_CHAN;
        for (int i = `MUPF_NCHAN - 1; i >= 0; i--)
        begin
            if (sel[i] && (3'(i) >= from))
            begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // Number of selected channels
    function automatic logic [2:0] chan_count(input logic [3:0] sel);
        logic [2:0] r;
        r = '0;
        for (int i = 0; i < `MUPF_NCHAN; i++)
        begin
            r = r + {2'h0, sel[i]};
        end
        return r;
    endfunction

    // Apply measurement direction to each channel
    genvar ch;
    generate
        for (ch = 0; ch < `MUPF_NCHAN; ch++)
        begin : g_dir
            assign samp_adj[ch] = q.dir_neg ? -sample_data[ch] : sample_data[ch];
        end
    endgenerate

    // Millisecond tick and nanosecond stamp
    mupf_timebase #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timebase (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .ts_ns   (ts_ns),
        .ms_tick (ms_tick)
    );

    // Ping-pong sample storage
    mupf_store u_store (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .sif   (sif.store)
    );

    // Next-state logic: commands, collection, frame start, byte sender
    always_comb
    begin
        logic                    swap;     // Boundary taken this cycle
        logic                    push_ok;  // Push may run
        logic                    eff_bank; // Bank taking a sample
        logic [`MUPF_SLOT_W:0]   eff_n;    // Slot taking a sample
        logic                    np_pl;
        logic [3:0]              np_h;
        logic [`MUPF_SLOT_W-1:0] np_t;
        logic [2:0]              np_c;
        logic [1:0]              np_b;
        logic [2:0]              nc;
        swap     = 1'b0;
        push_ok  = 1'b0;
        eff_bank = 1'b0;
        eff_n    = '0;
        np_pl    = q.in_pl;
        np_h     = q.hidx;
        np_t     = q.t;
        np_c     = q.c;
        np_b     = q.b;
        nc       = '0;
        d        = q;
        d.rsp_valid = 1'b0;
        d.rsp_err   = 1'b0;
        d.erase     = 1'b0;

        // commands taken from the control port
        if (cmd_valid)
        begin
            d.rsp_valid = 1'b1;
            d.rsp_data  = '0;
            case (cmd_addr)
                `MUPF_REG_CHAN_SEL:
                begin
                    // zero stops, up to 0x0F selects
                    if (!cmd_write)
                        d.rsp_data = {28'h0000000, q.sel};
                    else if (cmd_wdata[7:0] <= `MUPF_SEL_MAX)
                        d.sel = cmd_wdata[3:0];
                    else
                        d.rsp_err = 1'b1;  // Out of range, kept old
                end
                `MUPF_REG_ERASE:
                begin
                    if (cmd_write)
                    begin
                        d.erase_val = cmd_wdata[15:0];
                        // erase only on the exact code
                        d.erase = (cmd_wdata[15:0] == `MUPF_ERASE_CODE);
                    end
                    else
                    begin
                        d.rsp_data = {16'h0000, q.erase_val};
                    end
                end
                `MUPF_REG_DIRECTION:
                begin
                    if (cmd_write)
                        d.dir_neg = cmd_wdata[0];
                    else
                        d.rsp_data = {31'h00000000, q.dir_neg};
                end
                `MUPF_REG_PORT_LONG, `MUPF_REG_PORT_SHORT:
                begin
                    // both forms set the same 16-bit port
                    if (cmd_write)
                    begin
                        d.port     = cmd_wdata[15:0];
                        d.port_set = 1'b1;
                    end
                    else
                    begin
                        d.rsp_data = {16'h0000, q.port};
                    end
                end
                `MUPF_REG_TARGET_IP:
                begin
                    // first octet sits in the top byte
                    if (cmd_write)
                    begin
                        d.ip     = cmd_wdata;
                        d.ip_set = 1'b1;
                    end
                    else
                    begin
                        d.rsp_data = q.ip;
                    end
                end
                `MUPF_REG_TIMED_A:
                begin
                    // single timed value, channel A only
                    if (cmd_write)
                        d.rsp_err = 1'b1;
                    else
                        d.rsp_data = q.last_a;
                end
                default:
                begin
                    d.rsp_err = 1'b1;  // Unknown command
                end
            endcase
        end

        // target and channels must all be present
        push_ok  = (q.sel != 4'h0) && q.ip_set && q.port_set;
        d.active = push_ok;

        // Swap banks only while no frame is still going out
        swap     = ms_tick && (q.phase == mupf_pkg::MUPF_IDLE);
        eff_bank = swap ? ~q.wr_bank : q.wr_bank;
        eff_n    = swap ? '0 : q.n;

        // keep up to 16 samples of the millisecond
        d.n = eff_n;
        if (sample_valid)
        begin
            d.meas_cnt = q.meas_cnt + 32'h00000001;
            d.last_a   = samp_adj[0];
            if (eff_n == '0)
            begin
                d.first_ts  = ts_ns;
                d.first_cnt = q.meas_cnt;
            end
            // Bank full: extra samples dropped, counter shows the gap
            if (eff_n < (`MUPF_SLOT_W + 1)'(`MUPF_DEPTH))
                d.n = eff_n + 1'b1;
        end
        sif.wr_en   = sample_valid && (eff_n < (`MUPF_SLOT_W + 1)'(`MUPF_DEPTH));
        sif.wr_bank = eff_bank;
        sif.wr_slot = eff_n[`MUPF_SLOT_W-1:0];
        sif.wr_data = samp_adj;

        // boundary closes the bank and starts a frame when push may run
        if (swap)
        begin
            d.wr_bank = ~q.wr_bank;
            d.f_n     = q.n;
            // selection frozen for the whole frame
            d.f_sel   = q.sel;
            // length counts twelve plus four per value
            d.hdr     = {`MUPF_PUSH_ID,
                         12'(`MUPF_LEN_BASE + 12'(q.n) * 12'(chan_count(q.sel)) * 12'h004),
                         sensor_status, q.first_ts, q.first_cnt};
            if (push_ok)
            begin
                d.phase    = mupf_pkg::MUPF_SEND;
                d.in_pl    = 1'b0;
                d.hidx     = '0;
                d.tx_valid = 1'b1;
                d.tx_data  = d.hdr[`MUPF_HDR_W-1 -: 8];
                d.tx_last  = 1'b0;
                d.tx_ip    = q.ip;
                d.tx_port  = q.port;
            end
        end
        else if (q.phase == mupf_pkg::MUPF_SEND && q.tx_valid && tx_ready)
        begin
            if (q.tx_last)
            begin
                // Frame done, back to waiting for the boundary
                d.tx_valid = 1'b0;
                d.tx_last  = 1'b0;
                d.phase    = mupf_pkg::MUPF_IDLE;
            end
            else
            begin
                // walk oldest time first, channels within
                if (!q.in_pl)
                begin
                    if (q.hidx == `MUPF_HDR_LAST)
                    begin
                        np_pl = 1'b1;
                        np_t  = '0;
                        np_c  = next_chan(q.f_sel, 3'h0);
                        np_b  = '0;
                    end
                    else
                    begin
                        np_h = q.hidx + 4'h1;
                    end
                end
                else if (q.b != `MUPF_BYTE_LAST)
                begin
                    np_b = q.b + 2'h1;
                end
                else
                begin
                    nc   = next_chan(q.f_sel, q.c + 3'h1);
                    np_b = '0;
                    if (nc == `MUPF_NO_CHAN)
                    begin
                        np_t = q.t + 1'b1;
                        np_c = next_chan(q.f_sel, 3'h0);
                    end
                    else
                    begin
                        np_c = nc;
                    end
                end
                d.in_pl = np_pl;
                d.hidx  = np_h;
                d.t     = np_t;
                d.c     = np_c;
                d.b     = np_b;
                if (!np_pl)
                begin
                    d.tx_data = q.hdr[8 * (`MUPF_HDR_LAST - np_h) +: 8];
                    d.tx_last = (np_h == `MUPF_HDR_LAST) && (q.f_n == '0);
                end
                else
                begin
                    d.tx_data = sif.rd_data[8 * (`MUPF_BYTE_LAST - np_b) +: 8];
                    d.tx_last = (np_b == `MUPF_BYTE_LAST)
                              && (next_chan(q.f_sel, np_c + 3'h1) == `MUPF_NO_CHAN)
                              && ({1'b0, np_t} == q.f_n - 1'b1);
                end
            end
        end

        // Read the closed bank at the next byte position
        sif.rd_bank = ~q.wr_bank;
        sif.rd_slot = np_t;
        sif.rd_chan = np_c[1:0];
    end

    // Register the state; clock enable freezes everything
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q        <= '0;
            // frames leave from the data port
            q.tx_src <= `MUPF_DATA_PORT;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    // Outputs straight from the state flops
    assign rsp_valid   = q.rsp_valid;
    assign rsp_rdata   = q.rsp_data;
    assign rsp_err     = q.rsp_err;
    assign tx_valid    = q.tx_valid;
    assign tx_data     = q.tx_data;
    assign tx_last     = q.tx_last;
    assign tx_dst_ip   = q.tx_ip;
    assign tx_dst_port = q.tx_port;
    assign tx_src_port = q.tx_src;
    assign push_active = q.active;
    assign erase_all   = q.erase;
endmodule

// ==== bench/mupf_framer_asserts.sv ====
// Port checker for the push framer.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module mupf_framer_asserts (
    input logic        clk,
    input logic        rst_n,
    input logic        ce,
    input logic        cmd_valid,
    input logic        cmd_write,
    input logic [15:0] cmd_addr,
    input logic [31:0] cmd_wdata,
    input logic        rsp_valid,
    input logic        rsp_err,
    input logic        tx_valid,
    input logic        tx_ready,
    input logic [7:0]  tx_data,
    input logic        tx_last,
    input logic [15:0] tx_src_port,
    input logic        push_active,
    input logic        erase_all
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic wr_sel; // Selection write taken
    assign wr_sel = ce && cmd_valid && cmd_write && cmd_addr == 16'h01e0;
    a_rsp_answer: assert property (ce && cmd_valid |=> rsp_valid) else $error("no answer");
    a_sel_refused: assert property (wr_sel && cmd_wdata[7:0] > 8'h0f |=> rsp_err) else $error("bad sel taken");
    a_sel_stops: assert property (wr_sel && cmd_wdata[7:0] == 8'h00 |-> ##[1:2] !push_active)
        else $error("push not stopped");
    a_src_port: assert property (tx_src_port == 16'h1392) else $error("source port wrong");
    a_frame_ident: assert property ($rose(tx_valid) |-> tx_data[7:4] == 4'hd) else $error("bad ident");
    a_start_active: assert property ($rose(tx_valid) |-> $past(push_active)) else $error("frame unarmed");
    a_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("byte dropped");
    a_last_drop: assert property (ce && tx_valid && tx_ready && tx_last |=> !tx_valid) else $error("runs on");
    a_erase_pulse: assert property (ce && cmd_valid && cmd_write && cmd_addr == 16'h004c
        && cmd_wdata[15:0] == 16'h024e |-> ##[1:2] erase_all) else $error("no erase");
    a_erase_once: assert property (erase_all |=> !erase_all) else $error("erase too long");
    c_frame_end: cover property (tx_valid && tx_ready && tx_last);
    c_erase: cover property (erase_all);
    c_refused: cover property (rsp_valid && rsp_err);
endmodule
bind mupf_framer mupf_framer_asserts chk_u (.clk(clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .tx_src_port(tx_src_port),
    .push_active(push_active), .erase_all(erase_all));

// ==== bench/mupf_host_model.sv ====
// Receiving host: takes frame bytes, keeps the last frame.
// Assumes the bench reads fr and nfr by hierarchy.
`timescale 1ns/1ns
module mupf_host_model (
    input  logic       clk,
    input  logic       rst_n,
    input  logic       stall,
    input  logic       tx_valid,
    input  logic [7:0] tx_data,
    input  logic       tx_last,
    output logic       tx_ready
);
    logic [7:0] fr [0:127]; // Last frame bytes
    int         nb;         // Byte position
    int         nfr;        // Frames completed
    // Stalling host accepts every other cycle
    always @(posedge clk)
    begin
        tx_ready <= rst_n && (stall ? !tx_ready : 1'b1);
        if (!rst_n)
        begin
            nb <= 0;
            nfr <= 0;
        end
        else if (tx_valid && tx_ready)
        begin
            fr[nb[6:0]] <= tx_data;
            nb <= tx_last ? 0 : nb + 1;
            nfr <= nfr + (tx_last ? 1 : 0);
        end
    end
endmodule

// ==== bench/measurement_udp_push_framer_tb.sv ====
// Bench for the push framer: control commands, samples, frame checks.
// Assumes the host model as sink and a shortened millisecond.
`timescale 1ns/1ns
module measurement_udp_push_framer_tb;
    localparam int MS = 200; // Short millisecond
    logic clk = 0, rst_n = 0, cmd_valid = 0, cmd_write = 0, sample_valid = 0, stall = 0, pv = 0, er;
    logic [15:0] cmd_addr = 0, tx_dst_port, tx_src_port;
    logic [31:0] cmd_wdata = 0, rd, t0, t1, cyc = 0, rsp_rdata, tx_dst_ip;
    logic [3:0][31:0] sdat = '0;
    logic rsp_valid, rsp_err, tx_valid, tx_ready, tx_last, push_active, erase_all;
    logic [7:0] tx_data;
    int err_count = 0, num_checks = 0, n0;
    always #10 clk = ~clk;
    mupf_framer #(.MS_CYCLES(MS)) dut_u (.clk(clk), .rst_n(rst_n), .ce(1'b1), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .sample_valid(sample_valid), .sample_data(sdat),
        .sensor_status(32'h4000_0401), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .tx_last(tx_last), .tx_dst_ip(tx_dst_ip), .tx_dst_port(tx_dst_port), .tx_src_port(tx_src_port),
        .push_active(push_active), .erase_all(erase_all));
    mupf_host_model host_u (.clk(clk), .rst_n(rst_n), .stall(stall), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
    // Frame start stamps and hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        pv <= tx_valid;
        if (tx_valid && !pv)
        begin
            t1 <= t0;
            t0 <= cyc;
        end
        if (cyc == 32'd20000)
        begin
            err_count++;
            results();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One command, answer taken at the answer edge
    task cmd(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        {cmd_valid, cmd_write, cmd_addr, cmd_wdata} <= {1'b1, w, a, d};
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        rd = rsp_rdata;
        er = rsp_err;
        chk({31'h0, rsp_valid}, 32'h1);
    endtask
    task smp(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c, input logic [31:0] d);
        @(posedge clk);
        sample_valid <= 1'b1;
        sdat <= {d, c, b, a};
        @(posedge clk);
        sample_valid <= 1'b0;
    endtask
    // Wait for one whole frame, bounded
    task wfr;
        n0 = host_u.nfr;
        repeat (400) if (host_u.nfr == n0) @(posedge clk);
        chk(host_u.nfr, n0 + 1);
    endtask
    task chkw(input int i, input logic [31:0] e);
        chk({host_u.fr[i], host_u.fr[i+1], host_u.fr[i+2], host_u.fr[i+3]}, e);
    endtask
    task results;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        cmd(0, 16'h01e0, 0); chk(rd, 0);
        cmd(1, 16'h01e0, 32'h10); chk({31'h0, er}, 1);
        cmd(0, 16'h0123, 0); chk({31'h0, er}, 1); // Unmapped code refused
        cmd(1, 16'h10e4, 32'hc0a8000a);
        cmd(1, 16'h01e0, 32'h05);
        cmd(0, 16'h10e4, 0); chk(rd, 32'hc0a8000a); chk({31'h0, push_active}, 0);
        cmd(1, 16'h10e2, 32'h77fe);
        cmd(0, 16'h10e0, 0); chk(rd, 32'h77fe); chk({31'h0, push_active}, 1);
        @(posedge clk) stall <= 1'b1;
        wfr();
        for (int k = 0; k < 3; k++) smp(32'h00e8e450 + k, 32'h00123456, 32'hffaffdf8 - k, 32'hff000010);
        wfr();
        chkw(0, {4'hd, 12'd36, 16'h4000});
        chkw(2, 32'h4000_0401);
        chkw(10, 0);
        for (int k = 0; k < 3; k++) chkw(14 + 8 * k, 32'h00e8e450 + k);
        for (int k = 0; k < 3; k++) chkw(18 + 8 * k, 32'hffaffdf8 - k);
        chk(tx_dst_ip, 32'hc0a8000a); chk({16'h0, tx_dst_port}, 32'h77fe);
        chk({16'h0, tx_src_port}, 32'h1392);
        cmd(1, 16'h0ca4, 1); cmd(1, 16'h01e0, 32'h0a);
        for (int k = 0; k < 2; k++) smp(32'h1, 32'h00123456 + k, 32'h2, 32'hff000010 + k);
        wfr();
        chkw(0, {4'hd, 12'd28, 16'h4000});
        chkw(10, 3);
        for (int k = 0; k < 2; k++) chkw(14 + 8 * k, 32'h0 - (32'h00123456 + k));
        for (int k = 0; k < 2; k++) chkw(18 + 8 * k, 32'h0 - (32'hff000010 + k));
        chk(t0 - t1, MS);
        cmd(0, 16'h01f8, 0); chk(rd, 32'hffffffff);
        cmd(1, 16'h01f8, 0); chk({31'h0, er}, 1);
        cmd(1, 16'h01e0, 0); n0 = host_u.nfr;
        repeat (450) @(posedge clk);
        chk(host_u.nfr, n0); chk({31'h0, push_active}, 0);
        cmd(1, 16'h004c, 32'h024e); chk({31'h0, erase_all}, 1);
        cmd(0, 16'h004c, 0); chk(rd, 32'h024e);
        results();
    end
endmodule
